/* pkg/nsp_pkg.sv */
package nsp_pkg;

   // ***********************************************************
   // Bus geometry and responses.
   // ***********************************************************
   localparam int NSP_ADDR_W = 8;
   localparam int NSP_DATA_W = 32;
   localparam int NSP_STRB_W = 4;
   localparam logic [1:0] NSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] NSP_RESP_SLVERR = 2'h2;

   // ***********************************************************
   // Register offsets (byte addresses).
   // ***********************************************************
   localparam logic [7:0] NSP_OFF_SECTOR0 = 8'h00;
   localparam logic [7:0] NSP_OFF_PAGE_UPPER = 8'h04;
   localparam logic [7:0] NSP_OFF_SECTOR5 = 8'h14;
   localparam logic [7:0] NSP_OFF_CTRL = 8'h20;
   localparam logic [7:0] NSP_OFF_STATUS = 8'h24;

   // ***********************************************************
   // Field layout of the sector registers and the page register.
   // ***********************************************************
   localparam int NSP_NUM_SECTORS = 6;
   localparam int NSP_SECTOR_BYTES = 512;
   localparam int NSP_PAR_LSB = 12;
   localparam int NSP_PAR_W = 12;
   localparam int NSP_WORD_LSB = 3;
   localparam int NSP_WORD_W = 9;
   localparam int NSP_BIT_W = 3;
   localparam int NSP_SECTOR_W = 24;
   localparam int NSP_PAGE_PAR_W = 16;
   localparam int NSP_IDX_W = 3;

   // ***********************************************************
   // Control and status register fields and control reset value.
   // ***********************************************************
   localparam int NSP_CTRL_MODE_BIT = 0;
   localparam int NSP_CTRL_SIZE_LSB = 1;
   localparam logic [2:0] NSP_CTRL_RESET = 3'h0;
   localparam int NSP_STAT_MULTI_LSB = 8;

   typedef enum logic [1:0]
   {
      NSP_PAGE_512 = 2'b00,
      NSP_PAGE_2048 = 2'b01,
      NSP_PAGE_4096 = 2'b10,
      NSP_PAGE_RSVD = 2'b11
   } nsp_page_e;

   // Number of sector registers that a page of the given size fills.
   function automatic logic [3:0] nsp_sector_count(input nsp_page_e sel);
      logic [3:0] n;
      n = 4'h0;
      case (sel)
         NSP_PAGE_512: n = 4'h1;
         NSP_PAGE_2048: n = 4'h4;
         default: n = 4'(NSP_NUM_SECTORS);
      endcase
      return n;
   endfunction

endpackage

/* rtl/nsp_sector_store.sv */
`timescale 1ns/1ps
`default_nettype none
module nsp_sector_store
#(
   parameter int NUM = 6,
   parameter int WIDTH = 24
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic load,
   input wire logic [2:0] index,
   input wire logic [WIDTH-1:0] data,
   input wire logic clear,
   output logic [NUM-1:0][WIDTH-1:0] words,
   output logic [NUM-1:0] filled
);
   logic [NUM-1:0][WIDTH-1:0] next_words;
   logic [NUM-1:0] next_filled;

   // A load in the same cycle as a clear keeps its filled flag.
   always_comb
   begin
      next_words = words;
      next_filled = clear ? '0 : filled;
      for (int i = 0; i < NUM; i++)
      begin
         if (load && (32'(index) == i))
         begin
            next_words[i] = data;
            next_filled[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         words <= '0;
         filled <= '0;
      end
      else
      begin
         words <= next_words;
         filled <= next_filled;
      end
   end
endmodule
`default_nettype wire

/* rtl/nsp_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module nsp_axil_slave
import nsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [nsp_pkg::NSP_DATA_W-1:0] wdata,
   input wire logic [nsp_pkg::NSP_STRB_W-1:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [nsp_pkg::NSP_DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output logic [nsp_pkg::NSP_ADDR_W-1:0] wr_addr,
   output logic [nsp_pkg::NSP_DATA_W-1:0] wr_data,
   output logic [nsp_pkg::NSP_STRB_W-1:0] wr_strb,
   input wire logic wr_err,
   output logic rd_en,
   input wire logic [nsp_pkg::NSP_DATA_W-1:0] rd_data,
   input wire logic rd_err
);
   logic aw_held, next_aw_held;
   logic w_held, next_w_held;
   logic [NSP_ADDR_W-1:0] next_wr_addr;
   logic [NSP_DATA_W-1:0] next_wr_data;
   logic [NSP_STRB_W-1:0] next_wr_strb;
   logic next_bvalid, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [NSP_DATA_W-1:0] next_rdata;

   assign awready = !aw_held && !bvalid;
   assign wready = !w_held && !bvalid;
   assign arready = !rvalid;
   assign wr_en = aw_held && w_held && !bvalid;
   assign rd_en = arvalid && arready;

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      next_wr_strb = wr_strb;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      if (awvalid && awready)
      begin
         next_aw_held = 1'b1;
         next_wr_addr = awaddr;
      end
      if (wvalid && wready)
      begin
         next_w_held = 1'b1;
         next_wr_data = wdata;
         next_wr_strb = wstrb;
      end
      if (wr_en)
      begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_err ? NSP_RESP_SLVERR : NSP_RESP_OKAY;
      end
      else if (bvalid && bready)
      begin
         next_bvalid = 1'b0;
      end
      if (rd_en)
      begin
         next_rvalid = 1'b1;
         next_rdata = rd_data;
         next_rresp = rd_err ? NSP_RESP_SLVERR : NSP_RESP_OKAY;
      end
      else if (rvalid && rready)
      begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         bvalid <= 1'b0;
         bresp <= NSP_RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= NSP_RESP_OKAY;
         rdata <= '0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         wr_strb <= next_wr_strb;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
      end
   end
endmodule
`default_nettype wire

/* rtl/nsp_report_top.sv */
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module nsp_report_top
import nsp_pkg::*;
#(
   parameter int NUM_SECTORS = nsp_pkg::NSP_NUM_SECTORS
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [nsp_pkg::NSP_DATA_W-1:0] s_axi_wdata,
   input wire logic [nsp_pkg::NSP_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [nsp_pkg::NSP_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic page_start,
   input wire logic page_parity_load,
   input wire logic [nsp_pkg::NSP_PAGE_PAR_W-1:0] page_parity_upper_in,
   input wire logic sector_load,
   input wire logic [nsp_pkg::NSP_IDX_W-1:0] sector_index,
   input wire logic [nsp_pkg::NSP_PAR_W-1:0] sector_parity_in,
   input wire logic [nsp_pkg::NSP_WORD_W-1:0] faulty_word_location_in,
   input wire logic [nsp_pkg::NSP_BIT_W-1:0] faulty_bit_offset_in,
   input wire logic sector_multi_err,
   output logic sector_mode,
   output logic [1:0] page_size_sel
);

   // ***********************************************************
   // Declarations.
   // ***********************************************************
   logic wr_en;
   logic [NSP_ADDR_W-1:0] wr_addr;
   logic [NSP_DATA_W-1:0] wr_data;
   logic [NSP_STRB_W-1:0] wr_strb;
   logic wr_err;
   logic rd_en;
   logic [NSP_DATA_W-1:0] rd_data;
   logic rd_err;
   logic [NSP_PAGE_PAR_W-1:0] whole_page_parity_upper;
   logic [NSP_PAGE_PAR_W-1:0] next_page_upper;
   logic next_sector_mode;
   logic [1:0] next_page_size_sel;
   logic [NUM_SECTORS-1:0][NSP_SECTOR_W-1:0] sector_words;
   logic [NUM_SECTORS-1:0] sector_filled;
   logic [NUM_SECTORS-1:0] multi_err_mask;
   logic [NUM_SECTORS-1:0] next_multi_err_mask;
   logic [3:0] sector_count;
   logic sector_accept;
   logic [NSP_SECTOR_W-1:0] sector_word_in;

   // Word index of a byte address, used by the read decoder.
   function automatic logic [5:0] reg_index(input logic [7:0] a);
      return a[7:2];
   endfunction

   // Whether a byte address names one of the sector registers.
   function automatic logic is_sector(input logic [7:0] a);
      return (a >= NSP_OFF_SECTOR0) && (a <= NSP_OFF_SECTOR5);
   endfunction

   // ***********************************************************
   // Control register.
   // ***********************************************************
   // Writes to the control word select the code mode and page size;
   // the engine follows these outputs.
   always_comb
   begin
      next_sector_mode = sector_mode;
      next_page_size_sel = page_size_sel;
      if (wr_en && (wr_addr == NSP_OFF_CTRL) && wr_strb[0])
      begin
         next_sector_mode = wr_data[NSP_CTRL_MODE_BIT];
         next_page_size_sel = wr_data[NSP_CTRL_SIZE_LSB +: 2];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sector_mode <= NSP_CTRL_RESET[NSP_CTRL_MODE_BIT];
         page_size_sel <= NSP_CTRL_RESET[NSP_CTRL_SIZE_LSB +: 2];
      end
      else
      begin
         sector_mode <= next_sector_mode;
         page_size_sel <= next_page_size_sel;
      end
   end

   // ***********************************************************
   // Whole-page parity, upper half.
   // ***********************************************************
   // The engine hands the upper parity half over only in page mode.
   always_comb
   begin
      next_page_upper = whole_page_parity_upper;
      if (page_parity_load && !sector_mode)
      begin
         next_page_upper = page_parity_upper_in;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         whole_page_parity_upper <= '0;
      end
      else
      begin
         whole_page_parity_upper <= next_page_upper;
      end
   end

   // ***********************************************************
   // Sector register capture.
   // ***********************************************************
   // A sector index beyond the selected page size has no register and
   // its load is dropped.
   assign sector_count = nsp_sector_count(nsp_page_e'(page_size_sel));
   assign sector_accept = sector_load && sector_mode &&
      ({1'b0, sector_index} < sector_count);
   assign sector_word_in = {sector_parity_in,
      faulty_word_location_in,
      faulty_bit_offset_in};

   nsp_sector_store
   #(
      .NUM(NUM_SECTORS),
      .WIDTH(NSP_SECTOR_W)
   )
   u_store
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .load(sector_accept),
      .index(sector_index),
      .data(sector_word_in),
      .clear(page_start),
      .words(sector_words),
      .filled(sector_filled)
   );

   // Multiple-error flags let software tell when the location fields
   // of a sector cannot be trusted; a load beats a same-cycle clear.
   always_comb
   begin
      next_multi_err_mask = page_start ? '0 : multi_err_mask;
      for (int i = 0; i < NUM_SECTORS; i++)
      begin
         if (sector_accept && (32'(sector_index) == i))
         begin
            next_multi_err_mask[i] = sector_multi_err;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         multi_err_mask <= '0;
      end
      else
      begin
         multi_err_mask <= next_multi_err_mask;
      end
   end

   // ***********************************************************
   // Register read decode.
   // ***********************************************************
   // The second register is shared: page mode shows the page parity,
   // sector mode shows sector one.  Other sector offsets read zero in
   // page mode, as does any sector beyond the page size.
   always_comb
   begin
      logic [5:0] idx;
      idx = reg_index(s_axi_araddr);
      rd_data = '0;
      rd_err = 1'b0;
      if (is_sector(s_axi_araddr))
      begin
         if (!sector_mode)
         begin
            if (s_axi_araddr == NSP_OFF_PAGE_UPPER)
            begin
               rd_data = {16'h0000, whole_page_parity_upper};
            end
         end
         else if ({2'b00, idx} < {3'b000, sector_count})
         begin
            rd_data = {8'h00, sector_words[idx[2:0]]};
         end
      end
      else if (s_axi_araddr == NSP_OFF_CTRL)
      begin
         rd_data[NSP_CTRL_MODE_BIT] = sector_mode;
         rd_data[NSP_CTRL_SIZE_LSB +: 2] = page_size_sel;
      end
      else if (s_axi_araddr == NSP_OFF_STATUS)
      begin
         rd_data[NUM_SECTORS-1:0] = sector_filled;
         rd_data[NSP_STAT_MULTI_LSB +: NUM_SECTORS] = multi_err_mask;
      end
      else
      begin
         rd_err = 1'b1;
      end
   end

   // ***********************************************************
   // Register write decode.
   // ***********************************************************
   // Parity registers take writes with an OKAY answer and no effect;
   // only unmapped offsets answer with an error.
   always_comb
   begin
      wr_err = 1'b1;
      if (is_sector(wr_addr))
      begin
         wr_err = 1'b0;
      end
      else if ((wr_addr == NSP_OFF_CTRL) || (wr_addr == NSP_OFF_STATUS))
      begin
         wr_err = 1'b0;
      end
   end

   // ***********************************************************
   // Bus slave.
   // ***********************************************************
   nsp_axil_slave u_axil
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_err(wr_err),
      .rd_en(rd_en),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

endmodule
`default_nettype wire

/* verification/nsp_report_props.sv */
`timescale 1ns/1ps
`default_nettype none
module nsp_report_props
import nsp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [nsp_pkg::NSP_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [nsp_pkg::NSP_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sector_mode
);
   logic [NSP_ADDR_W-1:0] rd_a;
   logic [NSP_ADDR_W-1:0] wr_a;
   // Remembers the address of the access now being answered.
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_a <= '0;
         wr_a <= '0;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
            rd_a <= s_axi_araddr;
         if (s_axi_awvalid && s_axi_awready)
            wr_a <= s_axi_awaddr;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read not answered next cycle");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while answer pending");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   a_sector_rsvd: assert property (s_axi_rvalid &&
      rd_a <= NSP_OFF_SECTOR5 &&
      rd_a[1:0] == 2'h0 |-> s_axi_rdata[31:24] == 8'h00 &&
      s_axi_rresp == NSP_RESP_OKAY) else $error("sector reserved bits set");
   a_page_upper: assert property (s_axi_rvalid && !sector_mode &&
      rd_a == NSP_OFF_PAGE_UPPER |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("page parity reserved bits set");
   a_ro_write_ok: assert property (s_axi_bvalid &&
      wr_a <= NSP_OFF_SECTOR5 &&
      wr_a[1:0] == 2'h0 |-> s_axi_bresp == NSP_RESP_OKAY)
      else $error("parity write not answered okay");
   a_mode_source: assert property ($changed(sector_mode) |->
      wr_a == NSP_OFF_CTRL)
      else $error("mode moved without control write");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write not answered");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
endmodule
bind nsp_report_top nsp_report_props CHK (.core_clk, .rst_b, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sector_mode);
`default_nettype wire

/* verification/nsp_engine_model.sv */
`timescale 1ns/1ps
`default_nettype none
module nsp_engine_model
import nsp_pkg::*;
(
   input wire logic core_clk,
   output logic page_start,
   output logic page_parity_load,
   output logic [nsp_pkg::NSP_PAGE_PAR_W-1:0] page_parity_upper_in,
   output logic sector_load,
   output logic [nsp_pkg::NSP_IDX_W-1:0] sector_index,
   output logic [nsp_pkg::NSP_PAR_W-1:0] sector_parity_in,
   output logic [nsp_pkg::NSP_WORD_W-1:0] faulty_word_location_in,
   output logic [nsp_pkg::NSP_BIT_W-1:0] faulty_bit_offset_in,
   output logic sector_multi_err
);
   initial
   begin
      page_start = 1'b0;
      page_parity_load = 1'b0;
      page_parity_upper_in = '0;
      sector_load = 1'b0;
      sector_index = '0;
      sector_parity_in = '0;
      faulty_word_location_in = '0;
      faulty_bit_offset_in = '0;
      sector_multi_err = 1'b0;
   end
   task automatic pulse_start();
      page_start <= 1'b1;
      @(posedge core_clk);
      page_start <= 1'b0;
      @(posedge core_clk);
   endtask
   // Data lines show the inverse once the strobe has gone.
   task automatic load_page(input logic [15:0] par);
      page_parity_load <= 1'b1;
      page_parity_upper_in <= par;
      @(posedge core_clk);
      page_parity_load <= 1'b0;
      page_parity_upper_in <= ~par;
      @(posedge core_clk);
   endtask
   // The faulty byte is given as its byte address within the page.
   task automatic load_err(input logic [11:0] ba, input logic [11:0] par,
      input logic [2:0] bo, input logic multi);
      sector_load <= 1'b1;
      sector_index <= ba[11:9];
      faulty_word_location_in <= ba[8:0];
      faulty_bit_offset_in <= bo;
      sector_parity_in <= par;
      sector_multi_err <= multi;
      @(posedge core_clk);
      sector_load <= 1'b0;
      sector_index <= ~ba[11:9];
      faulty_word_location_in <= ~ba[8:0];
      faulty_bit_offset_in <= ~bo;
      sector_parity_in <= ~par;
      sector_multi_err <= ~multi;
      @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import nsp_pkg::*;
   logic core_clk, rst_b, sector_mode;
   logic [NSP_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [NSP_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [NSP_STRB_W-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, page_size_sel;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic page_start, page_parity_load, sector_load, sector_multi_err;
   logic [NSP_PAGE_PAR_W-1:0] page_parity_upper_in;
   logic [NSP_IDX_W-1:0] sector_index;
   logic [NSP_PAR_W-1:0] sector_parity_in;
   logic [NSP_WORD_W-1:0] faulty_word_location_in;
   logic [NSP_BIT_W-1:0] faulty_bit_offset_in;
   logic [31:0] exp_w [6];
   int errors, checked;
   nsp_report_top DUT (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .page_start, .page_parity_load, .page_parity_upper_in, .sector_load,
      .sector_index, .sector_parity_in, .faulty_word_location_in,
      .faulty_bit_offset_in, .sector_multi_err, .sector_mode, .page_size_sel);
   nsp_engine_model ENG (.core_clk, .page_start, .page_parity_load,
      .page_parity_upper_in, .sector_load, .sector_index, .sector_parity_in,
      .faulty_word_location_in, .faulty_bit_offset_in, .sector_multi_err);
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic wrap_up();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #200000;
      errors++;
      wrap_up();
   end
   task automatic chk_data(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_code(input string nm, input logic [1:0] e,
      input logic [1:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_exp(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er, input int lag);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge core_clk);
         aw_ok = aw_ok | s_axi_awready;
         w_ok = w_ok | s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      repeat (lag)
         @(posedge core_clk);
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
      while (!s_axi_bvalid)
         @(posedge core_clk);
      chk_code($sformatf("bresp@%h", a), er, s_axi_bresp);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd_exp(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er, input int lag);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge core_clk);
      while (!s_axi_arready)
         @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      repeat (lag)
         @(posedge core_clk);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      while (!s_axi_rvalid)
         @(posedge core_clk);
      chk_data($sformatf("rdata@%h", a), e, s_axi_rdata);
      chk_code($sformatf("rresp@%h", a), er, s_axi_rresp);
      s_axi_rready <= 1'b0;
   endtask
   initial
   begin
      logic [8:0] wl;
      logic [11:0] pa;
      logic [2:0] bo;
      errors = 0;
      checked = 0;
      rst_b = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      repeat (6)
         @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rd_exp(NSP_OFF_CTRL, 32'h00000000, NSP_RESP_OKAY, 0);
      ENG.load_page(16'hA5C3);
      ENG.load_err(12'h000, 12'hFFF, 3'h7, 1'b0);
      rd_exp(NSP_OFF_PAGE_UPPER, 32'h0000A5C3, NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_PAGE_UPPER, 32'hFFFFFFFF, NSP_RESP_OKAY, 3);
      rd_exp(NSP_OFF_PAGE_UPPER, 32'h0000A5C3, NSP_RESP_OKAY, 2);
      wr_exp(NSP_OFF_CTRL, 32'h00000005, NSP_RESP_OKAY, 0);
      chk_code("mode", 2'h1, {1'b0, sector_mode});
      chk_code("size", 2'h2, page_size_sel);
      for (int i = 0; i < 6; i++)
      begin
         wl = (i == 5) ? 9'h1FF : 9'(i * 73);
         pa = 12'(12'hA5A + i * 12'h111);
         bo = 3'(7 - i);
         exp_w[i] = {8'h00, pa, wl, bo};
         ENG.load_err(12'(i * 512) + {3'h0, wl}, pa, bo, 1'b0);
      end
      for (int i = 0; i < 6; i++)
      begin
         wr_exp(8'(4 * i), 32'hFFFFFFFF, NSP_RESP_OKAY, 0);
         rd_exp(8'(4 * i), exp_w[i], NSP_RESP_OKAY, i % 2);
      end
      rd_exp(NSP_OFF_STATUS, 32'h0000003F, NSP_RESP_OKAY, 0);
      ENG.load_err(12'h405, 12'h123, 3'h2, 1'b1);
      rd_exp(NSP_OFF_STATUS, 32'h0000043F, NSP_RESP_OKAY, 1);
      ENG.pulse_start();
      rd_exp(NSP_OFF_STATUS, 32'h00000000, NSP_RESP_OKAY, 0);
      rd_exp(8'h08, 32'h0012302A, NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_CTRL, 32'h00000003, NSP_RESP_OKAY, 0);
      rd_exp(8'h0C, exp_w[3], NSP_RESP_OKAY, 0);
      rd_exp(8'h10, 32'h00000000, NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_CTRL, 32'h00000001, NSP_RESP_OKAY, 0);
      ENG.load_err(12'h600, 12'h0F0, 3'h1, 1'b0);
      rd_exp(8'h00, exp_w[0], NSP_RESP_OKAY, 0);
      rd_exp(8'h04, 32'h00000000, NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_CTRL, 32'h00000005, NSP_RESP_OKAY, 0);
      rd_exp(8'h0C, exp_w[3], NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_STATUS, 32'hFFFFFFFF, NSP_RESP_OKAY, 0);
      rd_exp(8'h30, 32'h00000000, NSP_RESP_SLVERR, 0);
      rd_exp(8'h02, exp_w[0], NSP_RESP_OKAY, 0);
      wr_exp(8'h30, 32'h12345678, NSP_RESP_SLVERR, 1);
      wr_exp(NSP_OFF_CTRL, 32'h00000007, NSP_RESP_OKAY, 0);
      rd_exp(NSP_OFF_CTRL, 32'h00000007, NSP_RESP_OKAY, 0);
      rd_exp(NSP_OFF_SECTOR5, exp_w[5], NSP_RESP_OKAY, 0);
      wr_exp(NSP_OFF_CTRL, 32'h00000000, NSP_RESP_OKAY, 0);
      rd_exp(NSP_OFF_SECTOR0, 32'h00000000, NSP_RESP_OKAY, 0);
      rd_exp(NSP_OFF_PAGE_UPPER, 32'h0000A5C3, NSP_RESP_OKAY, 0);
      wrap_up();
   end
endmodule
`default_nettype wire
